// ---- tcwm_pin_load.sv ----
/*
 * Load model for the two compare pins of the timer.
 * Assumes pin_oe is high while the timer drives the pin.
 */
`timescale 1ns/10ps
module tcwm_pin_load (
	// Pin side
	input wire logic [1:0] pin_out,
	input wire logic [1:0] pin_oe,
	// Level seen by the load
	output logic [1:0] pin_level
);
	// A released pin falls to its pull-down, so a stale value never passes.
	assign pin_level = pin_out & pin_oe;
endmodule

// ---- tcwm_pkg.sv ----
/*
 * Constants and carrier types for the 8-bit timer compare and waveform block.
 * Assumes one 125 MHz clock with a synchronous active-high reset.
 */
package tcwm_pkg;
	localparam logic [2:0] TCWM_WGM_NORMAL = 3'h0;
	localparam logic [2:0] TCWM_WGM_CLEAR = 3'h2;
	localparam logic [2:0] TCWM_WGM_FAST_MAX = 3'h3;
	localparam logic [2:0] TCWM_WGM_FAST_A = 3'h7;
	localparam logic [1:0] TCWM_COM_NONE = 2'h0;
	localparam logic [1:0] TCWM_COM_TOGGLE = 2'h1;
	localparam logic [1:0] TCWM_COM_CLEAR = 2'h2;
	localparam logic [1:0] TCWM_COM_SET = 2'h3;
	localparam logic [7:0] TCWM_MAX = 8'h00_FF;
	localparam logic [7:0] TCWM_BOTTOM = 8'h00_00;
	localparam logic [7:0] TCWM_ONE = 8'h00_01;

	// Per-channel compare state.
	typedef struct packed {
		logic [7:0] compare_value;
		logic [7:0] compare_buffer;
		logic compare_output_state;
		logic compare_flag;
	} tcwm_chan_t;

	// Whole state of the block.
	typedef struct packed {
		logic [7:0] counter_value;
		logic block_match;
		logic overflow_flag;
		tcwm_chan_t [1:0] chan;
	} tcwm_state_t;
endpackage

// ---- tcwm_timer.sv ----
/*
 * Counter, two compare channels and pin override of an 8-bit timer.
 * Assumes timer_tick is a one-cycle enable from an outside prescaler and that all
 * control inputs come from logic on clk; the pin data path stays on clk too.
 */
`timescale 1ns/10ps
module tcwm_timer (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic timer_tick,
	// Mode control
	input wire logic [2:0] waveform_mode_select,
	input wire logic [1:0][1:0] compare_output_mode,
	// Processor writes
	input wire logic counter_write,
	input wire logic [7:0] counter_wdata,
	input wire logic [1:0] compare_write,
	input wire logic [7:0] compare_wdata,
	input wire logic [1:0] force_compare_strobe,
	input wire logic [1:0] state_preset,
	input wire logic [1:0] state_preset_value,
	input wire logic overflow_clear,
	input wire logic [1:0] compare_flag_clear,
	// Port
	input wire logic [1:0] port_data,
	input wire logic [1:0] compare_pin_direction_bit,
	output logic [1:0] pin_out,
	output logic [1:0] pin_oe,
	// Status
	output logic [7:0] counter_value,
	output logic overflow_flag,
	output logic [1:0] compare_flag
);
	tcwm_pkg::tcwm_state_t state_reg, state_next;
	logic fast_pwm, at_top, overflow_set;
	logic [7:0] top_value;
	logic [1:0] match;

	// Output action of one compare event; mode 0 leaves the state alone.
	function automatic logic apply_action(input logic cur, input logic [1:0] mode);
		case (mode)
			tcwm_pkg::TCWM_COM_TOGGLE: apply_action = ~cur;
			tcwm_pkg::TCWM_COM_CLEAR: apply_action = 1'b0;
			tcwm_pkg::TCWM_COM_SET: apply_action = 1'b1;
			default: apply_action = cur;
		endcase
	endfunction

	// Counting uses only the waveform mode and compare A; output modes never enter here.
	assign fast_pwm = (waveform_mode_select == tcwm_pkg::TCWM_WGM_FAST_MAX) ||
		(waveform_mode_select == tcwm_pkg::TCWM_WGM_FAST_A);
	assign top_value = (waveform_mode_select == tcwm_pkg::TCWM_WGM_FAST_MAX) ?
		tcwm_pkg::TCWM_MAX : state_reg.chan[0].compare_value;
	assign at_top = state_reg.counter_value == top_value;

	always_comb begin
		state_next = state_reg;
		overflow_set = 1'b0;
		for (int i = 0; i < 2; i++) begin
			match[i] = (state_reg.counter_value == state_reg.chan[i].compare_value) &&
				!state_reg.block_match;
		end
		if (timer_tick) begin
			state_next.block_match = 1'b0;
			if (fast_pwm) begin
				if (at_top) begin
					state_next.counter_value = tcwm_pkg::TCWM_BOTTOM;
					state_next.overflow_flag = 1'b1;
					overflow_set = 1'b1;
				end else begin
					state_next.counter_value = state_reg.counter_value + tcwm_pkg::TCWM_ONE;
				end
			end else if (waveform_mode_select == tcwm_pkg::TCWM_WGM_CLEAR && match[0]) begin
				state_next.counter_value = tcwm_pkg::TCWM_BOTTOM;
				// A top of MAX still passes from MAX to zero here.
				if (state_reg.counter_value == tcwm_pkg::TCWM_MAX) begin
					state_next.overflow_flag = 1'b1;
					overflow_set = 1'b1;
				end
			end else begin
				// Wrap past MAX also covers a compare A written below the count.
				state_next.counter_value = state_reg.counter_value + tcwm_pkg::TCWM_ONE;
				if (state_reg.counter_value == tcwm_pkg::TCWM_MAX) begin
					state_next.overflow_flag = 1'b1;
					overflow_set = 1'b1;
				end
			end
			for (int i = 0; i < 2; i++) begin
				if (match[i]) begin
					state_next.chan[i].compare_flag = 1'b1;
					state_next.chan[i].compare_output_state = apply_action(
						state_reg.chan[i].compare_output_state, compare_output_mode[i]);
				end
				if (fast_pwm && at_top) begin
					state_next.chan[i].compare_value = state_reg.chan[i].compare_buffer;
					if (compare_output_mode[i] == tcwm_pkg::TCWM_COM_CLEAR) begin
						state_next.chan[i].compare_output_state = 1'b1;
					end else if (compare_output_mode[i] == tcwm_pkg::TCWM_COM_SET) begin
						state_next.chan[i].compare_output_state = 1'b0;
					end
				end
			end
		end
		for (int i = 0; i < 2; i++) begin
			// Force acts at once in non-PWM modes without touching flag or counter.
			if (force_compare_strobe[i] && !fast_pwm) begin
				state_next.chan[i].compare_output_state = apply_action(
					state_reg.chan[i].compare_output_state, compare_output_mode[i]);
			end
			if (state_preset[i]) begin
				state_next.chan[i].compare_output_state = state_preset_value[i];
			end
			if (compare_write[i]) begin
				state_next.chan[i].compare_buffer = compare_wdata;
				if (!fast_pwm) begin
					state_next.chan[i].compare_value = compare_wdata;
				end
			end
			// Set wins over a simultaneous write-one clear.
			if (compare_flag_clear[i] && !(timer_tick && match[i])) begin
				state_next.chan[i].compare_flag = 1'b0;
			end
		end
		// Set wins over a simultaneous clear, even when the flag already stands.
		if (overflow_clear && !overflow_set) begin
			state_next.overflow_flag = 1'b0;
		end
		if (counter_write) begin
			state_next.counter_value = counter_wdata;
			state_next.block_match = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Pin selection sees only the output mode; direction still owns the enable.
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			pin_out[i] = (compare_output_mode[i] != tcwm_pkg::TCWM_COM_NONE) ?
				state_reg.chan[i].compare_output_state : port_data[i];
			pin_oe[i] = compare_pin_direction_bit[i];
		end
	end

	assign counter_value = state_reg.counter_value;
	assign overflow_flag = state_reg.overflow_flag;
	assign compare_flag = {state_reg.chan[1].compare_flag, state_reg.chan[0].compare_flag};

	// Steps of a blocked match: a counter load, then a quiet tick in the very next cycle.
	sequence s_counter_load;
		counter_write;
	endsequence

	sequence s_quiet_tick;
		timer_tick && !counter_write && compare_flag_clear == 2'h0;
	endsequence

	// The tick on which a fast PWM count leaves its top value.
	sequence s_fast_top;
		timer_tick && fast_pwm && at_top;
	endsequence

	a_normal_wrap: assert property (@(posedge clk) disable iff (sys_rst)
		timer_tick && !counter_write && waveform_mode_select == tcwm_pkg::TCWM_WGM_NORMAL
		&& counter_value == tcwm_pkg::TCWM_MAX |=> counter_value == tcwm_pkg::TCWM_BOTTOM)
		else $error("normal mode did not wrap");
	a_overflow_on_wrap: assert property (@(posedge clk) disable iff (sys_rst)
		timer_tick && !counter_write && !fast_pwm && counter_value == tcwm_pkg::TCWM_MAX
		|=> overflow_flag)
		else $error("overflow not set on wrap");
	a_clear_match: assert property (@(posedge clk) disable iff (sys_rst)
		timer_tick && !counter_write && waveform_mode_select == tcwm_pkg::TCWM_WGM_CLEAR
		&& match[0] |=> counter_value == tcwm_pkg::TCWM_BOTTOM)
		else $error("clear mode did not clear on match");
	a_fast_top: assert property (@(posedge clk) disable iff (sys_rst)
		timer_tick && !counter_write && fast_pwm && at_top
		|=> counter_value == tcwm_pkg::TCWM_BOTTOM && overflow_flag)
		else $error("fast pwm top not handled");
	a_flag_set: assert property (@(posedge clk) disable iff (sys_rst)
		timer_tick && match[0] |=> compare_flag[0])
		else $error("compare flag not set");
	a_write_blocks: assert property (@(posedge clk) disable iff (sys_rst)
		s_counter_load ##1 s_quiet_tick |=> $stable(compare_flag))
		else $error("match not blocked after write");
	a_pin_override: assert property (@(posedge clk) disable iff (sys_rst)
		compare_output_mode[0] != tcwm_pkg::TCWM_COM_NONE
		|-> pin_out[0] == state_reg.chan[0].compare_output_state)
		else $error("pin not overridden");
	a_mode_zero_hold: assert property (@(posedge clk) disable iff (sys_rst)
		compare_output_mode[0] == tcwm_pkg::TCWM_COM_NONE && !state_preset[0]
		|=> $stable(state_reg.chan[0].compare_output_state))
		else $error("mode zero changed state");

	a_mode_zero_hold_b: assert property (@(posedge clk) disable iff (sys_rst)
		compare_output_mode[1] == tcwm_pkg::TCWM_COM_NONE && !state_preset[1]
		|=> $stable(state_reg.chan[1].compare_output_state))
		else $error("mode zero changed state b");

	a_pin_port_a: assert property (@(posedge clk) disable iff (sys_rst)
		compare_output_mode[0] == tcwm_pkg::TCWM_COM_NONE
		|-> pin_out[0] == port_data[0])
		else $error("port data not on pin a");

	a_pin_override_b: assert property (@(posedge clk) disable iff (sys_rst)
		compare_output_mode[1] != tcwm_pkg::TCWM_COM_NONE
		|-> pin_out[1] == state_reg.chan[1].compare_output_state)
		else $error("pin b not overridden");

	a_pin_port_b: assert property (@(posedge clk) disable iff (sys_rst)
		compare_output_mode[1] == tcwm_pkg::TCWM_COM_NONE
		|-> pin_out[1] == port_data[1])
		else $error("port data not on pin b");

	a_pin_direction: assert property (@(posedge clk) disable iff (sys_rst)
		1'b1
		|-> pin_oe == compare_pin_direction_bit)
		else $error("pin enable not from direction bit");

	a_count_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!timer_tick && !counter_write
		|=> $stable(counter_value))
		else $error("counter moved without tick");

	a_counter_load: assert property (@(posedge clk) disable iff (sys_rst)
		counter_write
		|=> counter_value == $past(counter_wdata))
		else $error("counter write lost");

	a_normal_step: assert property (@(posedge clk) disable iff (sys_rst)
		timer_tick && !counter_write && waveform_mode_select == tcwm_pkg::TCWM_WGM_NORMAL
		&& counter_value != tcwm_pkg::TCWM_MAX |=> counter_value == $past(counter_value) + 8'h01)
		else $error("normal mode did not count up");

	a_fast_step: assert property (@(posedge clk) disable iff (sys_rst)
		timer_tick && !counter_write && fast_pwm && !at_top
		|=> counter_value == $past(counter_value) + 8'h01)
		else $error("fast pwm did not count up");

	a_clear_step: assert property (@(posedge clk) disable iff (sys_rst)
		timer_tick && !counter_write && waveform_mode_select == tcwm_pkg::TCWM_WGM_CLEAR
		&& !match[0] && counter_value != tcwm_pkg::TCWM_MAX |=> counter_value == $past(counter_value) + 8'h01)
		else $error("clear mode did not count past a missed match");

	a_overflow_sticky: assert property (@(posedge clk) disable iff (sys_rst)
		overflow_flag && !overflow_clear
		|=> overflow_flag)
		else $error("overflow flag cleared by counting");

	a_overflow_clear: assert property (@(posedge clk) disable iff (sys_rst)
		overflow_clear && !timer_tick
		|=> !overflow_flag)
		else $error("overflow flag not cleared");

	a_flag_sticky: assert property (@(posedge clk) disable iff (sys_rst)
		compare_flag[0] && !compare_flag_clear[0]
		|=> compare_flag[0])
		else $error("compare flag dropped");

	a_flag_clear: assert property (@(posedge clk) disable iff (sys_rst)
		compare_flag_clear[0] && !timer_tick
		|=> !compare_flag[0])
		else $error("compare flag not cleared");

	a_flag_set_b: assert property (@(posedge clk) disable iff (sys_rst)
		timer_tick && match[1]
		|=> compare_flag[1])
		else $error("compare flag b not set");

	a_force_clears: assert property (@(posedge clk) disable iff (sys_rst)
		force_compare_strobe[0] && !fast_pwm && !state_preset[0]
		&& compare_output_mode[0] == tcwm_pkg::TCWM_COM_CLEAR |=> !state_reg.chan[0].compare_output_state)
		else $error("force did not clear");

	a_force_sets: assert property (@(posedge clk) disable iff (sys_rst)
		force_compare_strobe[0] && !fast_pwm && !state_preset[0]
		&& compare_output_mode[0] == tcwm_pkg::TCWM_COM_SET |=> state_reg.chan[0].compare_output_state)
		else $error("force did not set");

	a_force_quiet: assert property (@(posedge clk) disable iff (sys_rst)
		force_compare_strobe[0] && !timer_tick && !counter_write && !compare_flag_clear[0]
		|=> $stable(compare_flag[0]) && $stable(counter_value))
		else $error("force touched flag or counter");

	a_force_ignored: assert property (@(posedge clk) disable iff (sys_rst)
		force_compare_strobe[0] && fast_pwm && !timer_tick && !state_preset[0]
		|=> $stable(state_reg.chan[0].compare_output_state))
		else $error("force acted in fast pwm");

	a_preset_loads: assert property (@(posedge clk) disable iff (sys_rst)
		state_preset[0]
		|=> state_reg.chan[0].compare_output_state == $past(state_preset_value[0]))
		else $error("preset value not loaded");

	a_toggle_match: assert property (@(posedge clk) disable iff (sys_rst)
		timer_tick && match[0] && compare_output_mode[0] == tcwm_pkg::TCWM_COM_TOGGLE
		&& !force_compare_strobe[0] && !state_preset[0] |=> $changed(state_reg.chan[0].compare_output_state))
		else $error("match did not toggle");

	a_pwm_bottom_set: assert property (@(posedge clk) disable iff (sys_rst)
		s_fast_top ##0 (compare_output_mode[0] == tcwm_pkg::TCWM_COM_CLEAR && !state_preset[0])
		|=> state_reg.chan[0].compare_output_state)
		else $error("bottom did not set output");

	a_pwm_bottom_clr: assert property (@(posedge clk) disable iff (sys_rst)
		s_fast_top ##0 (compare_output_mode[0] == tcwm_pkg::TCWM_COM_SET && !state_preset[0])
		|=> !state_reg.chan[0].compare_output_state)
		else $error("bottom did not clear output");

	a_pwm_match_clr: assert property (@(posedge clk) disable iff (sys_rst)
		timer_tick && fast_pwm && match[0] && !at_top && !state_preset[0]
		&& compare_output_mode[0] == tcwm_pkg::TCWM_COM_CLEAR |=> !state_reg.chan[0].compare_output_state)
		else $error("match did not clear output");

	a_pwm_match_set: assert property (@(posedge clk) disable iff (sys_rst)
		timer_tick && fast_pwm && match[0] && !at_top && !state_preset[0]
		&& compare_output_mode[0] == tcwm_pkg::TCWM_COM_SET |=> state_reg.chan[0].compare_output_state)
		else $error("match did not set output");

	a_buffer_copy: assert property (@(posedge clk) disable iff (sys_rst)
		s_fast_top
		|=> state_reg.chan[0].compare_value == $past(state_reg.chan[0].compare_buffer))
		else $error("compare buffer not copied at top");

	a_direct_write: assert property (@(posedge clk) disable iff (sys_rst)
		compare_write[0] && !fast_pwm
		|=> state_reg.chan[0].compare_value == $past(compare_wdata))
		else $error("direct compare write lost");

	a_pwm_buffered: assert property (@(posedge clk) disable iff (sys_rst)
		compare_write[0] && fast_pwm && !(timer_tick && at_top)
		|=> $stable(state_reg.chan[0].compare_value))
		else $error("fast pwm compare write not buffered");
endmodule

// ---- tcwm_timer_tb_top.sv ----
/*
 * Self-checking bench for the timer compare and waveform block.
 * Assumes the package, the timer and the pin load model are compiled first.
 */
`timescale 1ns/10ps
module tcwm_timer_tb_top;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic timer_tick = 1'b0;
	logic [2:0] waveform_mode_select = 3'h0;
	logic [1:0][1:0] compare_output_mode = 4'h0;
	logic counter_write = 1'b0;
	logic [7:0] counter_wdata = 8'h00;
	logic [1:0] compare_write = 2'h0;
	logic [7:0] compare_wdata = 8'h00;
	logic [1:0] force_compare_strobe = 2'h0;
	logic [1:0] state_preset = 2'h0;
	logic [1:0] state_preset_value = 2'h0;
	logic overflow_clear = 1'b0;
	logic [1:0] compare_flag_clear = 2'h0;
	logic [1:0] port_data = 2'h2;
	logic [1:0] compare_pin_direction_bit = 2'h2;
	logic [1:0] pin_out;
	logic [1:0] pin_oe;
	logic [1:0] pin_level;
	logic [1:0] compare_flag;
	logic [7:0] counter_value;
	logic overflow_flag;
	int mismatches = 0;
	int n_tests = 0;
	int cycles = 0;

	tcwm_timer DUT (.clk, .sys_rst, .timer_tick, .waveform_mode_select, .compare_output_mode,
		.counter_write, .counter_wdata, .compare_write, .compare_wdata, .force_compare_strobe,
		.state_preset, .state_preset_value, .overflow_clear, .compare_flag_clear, .port_data,
		.compare_pin_direction_bit, .pin_out, .pin_oe, .counter_value, .overflow_flag,
		.compare_flag);
	tcwm_pin_load LOAD (.pin_out, .pin_oe, .pin_level);

	always #4 clk = ~clk;

	task automatic summarize();
		if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// The whole run takes well under a thousand cycles.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			mismatches++;
			summarize();
		end
	end

	task automatic chk(logic [7:0] got, logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic go(int n);
		@(posedge clk);
		timer_tick <= 1'b1;
		repeat (n) @(posedge clk);
		timer_tick <= 1'b0;
		#1;
	endtask

	task automatic wr_cnt(logic [7:0] v);
		@(posedge clk);
		counter_write <= 1'b1;
		counter_wdata <= v;
		@(posedge clk);
		counter_write <= 1'b0;
		#1;
	endtask

	task automatic wr_cmp(int ch, logic [7:0] v);
		@(posedge clk);
		compare_write[ch] <= 1'b1;
		compare_wdata <= v;
		@(posedge clk);
		compare_write <= 2'h0;
		#1;
	endtask

	// Mode change also clears both flags so each step starts clean.
	task automatic cfg(logic [2:0] w, logic [3:0] com);
		@(posedge clk);
		waveform_mode_select <= w;
		compare_output_mode <= com;
		overflow_clear <= 1'b1;
		compare_flag_clear <= 2'h3;
		@(posedge clk);
		overflow_clear <= 1'b0;
		compare_flag_clear <= 2'h0;
		#1;
	endtask

	initial begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		wr_cmp(1, 8'h02);
		wr_cnt(8'hFE);
		go(1);
		chk(counter_value, 8'hFF);
		chk(pin_level, 2'h2);
		go(1);
		chk(counter_value, 8'h00);
		chk(overflow_flag, 1'b1);
		@(posedge clk);
		state_preset <= 2'h1;
		state_preset_value <= 2'h1;
		compare_output_mode[0] <= 2'h2;
		@(posedge clk);
		state_preset <= 2'h0;
		#1;
		chk(pin_oe, 2'h2);
		chk(pin_level, 2'h2);
		@(posedge clk);
		compare_pin_direction_bit <= 2'h3;
		#1;
		chk(pin_level, 2'h3);
		@(posedge clk);
		force_compare_strobe <= 2'h1;
		@(posedge clk);
		force_compare_strobe <= 2'h0;
		#1;
		chk(pin_level, 2'h2);
		chk(compare_flag, 2'h0);
		chk(counter_value, 8'h00);
		cfg(3'h2, 4'h1);
		wr_cmp(0, 8'h03);
		wr_cnt(8'h00);
		go(4);
		chk(counter_value, 8'h00);
		chk(pin_level, 2'h3);
		chk(compare_flag, 2'h3);
		chk(overflow_flag, 1'b0);
		go(2);
		wr_cmp(0, 8'h01);
		go(254);
		chk(counter_value, 8'h00);
		chk(overflow_flag, 1'b1);
		wr_cnt(8'h01);
		go(1);
		chk(counter_value, 8'h02);
		cfg(3'h7, 4'h8);
		wr_cnt(8'h00);
		wr_cmp(0, 8'h04);
		go(2);
		chk(counter_value, 8'h00);
		chk(overflow_flag, 1'b1);
		chk(pin_level, 2'h2);
		go(3);
		chk(pin_level, 2'h0);
		cfg(3'h7, 4'h8);
		go(2);
		chk(counter_value, 8'h00);
		chk(overflow_flag, 1'b1);
		cfg(3'h3, 4'hC);
		wr_cnt(8'hFE);
		go(2);
		chk(counter_value, 8'h00);
		chk(pin_level, 2'h0);
		go(3);
		chk(pin_level, 2'h2);
		summarize();
	end
endmodule
